// ==== src/link_pkg.sv ====
// Shared constants and carrier types for the single-wire debug link
package link_pkg;
    // Bit timing in debug clock cycles; ALT_DIV is bus clock cycles per debug tick
    localparam int BIT_CYCLES      = 16;
    localparam int SAMPLE_AT       = 10;
    localparam int ONE_PULSE_AT    = 7;
    localparam int ZERO_LOW        = 13;
    localparam int TIMEOUT_CYCLES  = 512;
    localparam int SYNC_DETECT     = 128;
    localparam int SYNC_PULSE      = 128;
    localparam int DELAY_CYCLES    = 16;
    localparam int ALT_DIV         = 4;
    // Status and control layout
    localparam int ST_ENABLE       = 7;
    localparam int ST_ACTIVE       = 6;
    localparam int ST_CLKSEL       = 2;
    localparam logic CTL_RESET     = 1'b0;
    // Field lengths in bits
    localparam logic [4:0] B0      = 5'h00;
    localparam logic [4:0] B8      = 5'h08;
    localparam logic [4:0] B16     = 5'h10;
    localparam logic [4:0] B24     = 5'h18;
    // Command codes
    localparam logic [7:0] CMD_READ_STATUS = 8'he4, CMD_WRITE_CONTROL = 8'hc4;
    localparam logic [7:0] CMD_BACKGROUND  = 8'h90, CMD_READ_BYTE     = 8'he0;
    localparam logic [7:0] CMD_READ_BYTE_S = 8'he1, CMD_READ_LAST     = 8'he8;
    localparam logic [7:0] CMD_WRITE_BYTE  = 8'hc0, CMD_WRITE_BYTE_S  = 8'hc1;
    localparam logic [7:0] CMD_GO          = 8'h08, CMD_SINGLE_STEP   = 8'h10;
    localparam logic [7:0] CMD_TAGGO       = 8'h18, CMD_READ_A        = 8'h68;
    localparam logic [7:0] CMD_READ_CCR    = 8'h69, CMD_READ_PC       = 8'h6b;
    localparam logic [7:0] CMD_READ_HX     = 8'h6c, CMD_READ_SP       = 8'h6f;
    localparam logic [7:0] CMD_READ_NEXT   = 8'h70, CMD_READ_NEXT_S   = 8'h71;
    localparam logic [7:0] CMD_WRITE_A     = 8'h48, CMD_WRITE_CCR     = 8'h49;
    localparam logic [7:0] CMD_WRITE_PC    = 8'h4b, CMD_WRITE_HX      = 8'h4c;
    localparam logic [7:0] CMD_WRITE_SP    = 8'h4f, CMD_WRITE_NEXT    = 8'h50;

    typedef struct packed {
        logic        valid;
        logic [7:0]  code;
        logic [15:0] addr;
        logic [15:0] wdata;
    } core_req_t;

    typedef struct packed {
        logic       known;
        logic       halted_only;
        logic       exec;
        logic       addr_cmd;
        logic       with_status;
        logic [4:0] rx_len;
        logic [4:0] tx_len;
    } cmd_desc_t;
endpackage

// ==== src/bit_timer.sv ====
// Bit-level timing engine for the debug line: edges, sampling, drive, sync, timeout
`timescale 1ns/100ps
module bit_timer import link_pkg::*; (
    input  wire logic mclk,
    input  wire logic rst_n,
    input  wire logic tick,
    input  wire logic line_in,
    input  wire logic tx_mode,
    input  wire logic tx_bit,
    output logic      sample_p,
    output logic      rx_bit,
    output logic      timeout_p,
    output logic      sync_p,
    output logic      line_o,
    output logic      line_oe
);
    typedef enum logic [2:0] {P_IDLE, P_BIT, P_SYNC_REL, P_SYNC_GAP, P_SYNC_DRV} phase_t;

    phase_t     phase_reg, phase_next;
    logic       s1_reg, s2_reg, s3_reg;
    logic [9:0] cnt_reg, cnt_next, idle_reg;
    logic       xmit_reg, xmit_next, bitv_reg, bitv_next;
    logic       drv_low, drv_high;

    // Own drive masks the line so our low never looks like a host edge
    wire fell      = s3_reg & ~s2_reg & ~line_oe;
    wire at_sample = (phase_reg == P_BIT) && (cnt_reg == 10'(SAMPLE_AT));

    always_comb
    begin
        phase_next = phase_reg;
        cnt_next   = cnt_reg;
        xmit_next  = xmit_reg;
        bitv_next  = bitv_reg;
        if (fell && (phase_reg == P_IDLE || phase_reg == P_BIT))
        begin
            phase_next = P_BIT;
            cnt_next   = '0;
            xmit_next  = tx_mode;
            bitv_next  = tx_bit;
        end
        else
        begin
            case (phase_reg)
                P_IDLE: ;
                P_BIT:
                    if (cnt_reg == 10'(SYNC_DETECT - 1))
                        phase_next = s2_reg ? P_IDLE : P_SYNC_REL;
                    else
                        cnt_next = cnt_reg + 10'h001;
                P_SYNC_REL:
                    if (s2_reg)
                    begin
                        phase_next = P_SYNC_GAP;
                        cnt_next   = '0;
                    end
                P_SYNC_GAP:
                    if (cnt_reg == 10'(BIT_CYCLES - 1))
                    begin
                        phase_next = P_SYNC_DRV;
                        cnt_next   = '0;
                    end
                    else
                        cnt_next = cnt_reg + 10'h001;
                P_SYNC_DRV:
                    if (cnt_reg == 10'(SYNC_PULSE))
                        phase_next = P_IDLE;
                    else
                        cnt_next = cnt_reg + 10'h001;
                default: phase_next = P_IDLE;
            endcase
        end
    end

    // Drive computed from next state so the pin lines up with the count
    assign drv_low  = (phase_next == P_BIT && xmit_next && !bitv_next
                       && cnt_next < 10'(ZERO_LOW))
                    || (phase_next == P_SYNC_DRV && cnt_next < 10'(SYNC_PULSE));
    assign drv_high = (phase_next == P_BIT && xmit_next && bitv_next
                       && cnt_next == 10'(ONE_PULSE_AT))
                    || (phase_next == P_BIT && xmit_next && !bitv_next
                       && cnt_next == 10'(ZERO_LOW))
                    || (phase_next == P_SYNC_DRV && cnt_next == 10'(SYNC_PULSE));

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            s1_reg    <= 1'b1;
            s2_reg    <= 1'b1;
            s3_reg    <= 1'b1;
            phase_reg <= P_IDLE;
            cnt_reg   <= '0;
            idle_reg  <= '0;
            xmit_reg  <= 1'b0;
            bitv_reg  <= 1'b0;
            line_o    <= 1'b0;
            line_oe   <= 1'b0;
            rx_bit    <= 1'b0;
            sample_p  <= 1'b0;
            timeout_p <= 1'b0;
            sync_p    <= 1'b0;
        end
        else
        begin
            sample_p  <= tick & at_sample;
            timeout_p <= tick & ~fell & (idle_reg == 10'(TIMEOUT_CYCLES - 1));
            sync_p    <= tick & (phase_reg == P_BIT) & (phase_next == P_SYNC_REL);
            if (tick)
            begin
                s1_reg    <= line_in;
                s2_reg    <= s1_reg;
                s3_reg    <= s2_reg;
                phase_reg <= phase_next;
                cnt_reg   <= cnt_next;
                xmit_reg  <= xmit_next;
                bitv_reg  <= bitv_next;
                line_oe   <= drv_low | drv_high;
                line_o    <= drv_high;
                if (at_sample)
                    rx_bit <= s2_reg;
                if (fell)
                    idle_reg <= '0;
                else if (idle_reg != 10'(TIMEOUT_CYCLES))
                    idle_reg <= idle_reg + 10'h001;
            end
        end
    end

    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);

    a_quiet_receive: assert property (phase_reg == P_BIT && !xmit_reg |-> !line_oe)
        else $error("line driven during host-to-target bit");
    a_zero_speedup: assert property (phase_reg == P_BIT && xmit_reg && !bitv_reg
        && cnt_reg < 10'(ZERO_LOW) && line_oe |-> !line_o)
        else $error("zero bit not held low for its low time");
    a_zero_release: assert property (phase_reg == P_BIT && xmit_reg && !bitv_reg
        && cnt_reg == 10'(ZERO_LOW) |-> line_oe && line_o)
        else $error("zero bit missing speed-up at end of low time");
    a_one_pulse: assert property (phase_reg == P_BIT && xmit_reg && bitv_reg
        && line_oe |-> line_o && cnt_reg == 10'(ONE_PULSE_AT))
        else $error("one bit speed-up at wrong count");
    a_sample_point: assert property (sample_p |-> $past(at_sample))
        else $error("sample pulse not at sample count");
    a_timeout_gap: assert property (timeout_p |-> idle_reg == 10'(TIMEOUT_CYCLES))
        else $error("timeout before full idle count");
endmodule

// ==== src/single_wire_debug_link.sv ====
// Target-side single-wire debug link: command framing and execution requests
`timescale 1ns/100ps
module single_wire_debug_link import link_pkg::*; (
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic        line_in,
    output logic             line_o,
    output logic             line_oe,
    input  wire logic        cpu_halted,
    input  wire logic        core_ack,
    input  wire logic [15:0] core_rdata,
    output core_req_t        core_req,
    output logic             start_in_background
);
    typedef enum logic [1:0] {S_CMD, S_RX, S_EXEC, S_TX} state_t;

    ////////////////////////////////////////////////////////////////////////////
    // Command table

    function automatic cmd_desc_t decode(input logic [7:0] c);
        cmd_desc_t d;
        d = '0;
        case (c)
            CMD_READ_STATUS:  d = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1, B0,  B8};
            CMD_WRITE_CONTROL: d = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, B8,  B0};
            CMD_BACKGROUND:   d = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, B0,  B0};
            CMD_READ_BYTE:    d = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, B16, B8};
            CMD_READ_BYTE_S:  d = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, B16, B16};
            CMD_READ_LAST:    d = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, B0,  B16};
            CMD_WRITE_BYTE:   d = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, B24, B0};
            CMD_WRITE_BYTE_S: d = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, B24, B8};
            CMD_GO, CMD_SINGLE_STEP, CMD_TAGGO:
                              d = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, B0,  B0};
            CMD_READ_A, CMD_READ_CCR, CMD_READ_NEXT:
                              d = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, B0,  B8};
            CMD_READ_PC, CMD_READ_HX, CMD_READ_SP:
                              d = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, B0,  B16};
            CMD_READ_NEXT_S:  d = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1, B0,  B16};
            CMD_WRITE_A, CMD_WRITE_CCR, CMD_WRITE_NEXT:
                              d = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, B8,  B0};
            CMD_WRITE_PC, CMD_WRITE_HX, CMD_WRITE_SP:
                              d = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, B16, B0};
            default:          d = '0;
        endcase
        return d;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    state_t      state_reg;
    cmd_desc_t   desc_reg;
    logic [7:0]  code_reg;
    logic [4:0]  nbits_reg;
    logic [23:0] rx_sh_reg;
    logic [15:0] tx_sh_reg;
    logic [15:0] last_addr_reg;
    logic        ignore_reg, pend_reg;
    logic        enable_reg, clksel_reg;
    logic        strap_done_reg;
    logic [1:0]  alt_cnt_reg;
    logic        alt_tick_reg;
    logic        sample_p, rx_bit, timeout_p, sync_p;

    ////////////////////////////////////////////////////////////////////////////
    // Debug clock: bus rate or divided alternate rate

    wire tick = clksel_reg ? alt_tick_reg : 1'b1;

    ////////////////////////////////////////////////////////////////////////////
    // Decode and datapath selection

    wire [7:0]  code_shift = {code_reg[6:0], rx_bit};
    wire        code_done  = (state_reg == S_CMD) && sample_p && (nbits_reg == B8 - 5'h01);
    cmd_desc_t  new_desc;
    assign new_desc = decode(code_shift);
    wire        new_ignore = (new_desc.halted_only && !cpu_halted)
                          || (code_shift == CMD_BACKGROUND && !enable_reg);
    wire        rx_done    = (state_reg == S_RX) && sample_p
                          && (nbits_reg == desc_reg.rx_len - 5'h01);
    wire        tx_done    = (state_reg == S_TX) && sample_p
                          && (nbits_reg == desc_reg.tx_len - 5'h01);
    wire        need_exec  = desc_reg.exec && !ignore_reg;
    wire        exec_done  = (state_reg == S_EXEC) && (!need_exec || (pend_reg && core_ack));
    wire        abort      = timeout_p || sync_p;

    wire [7:0]  status_v   = (8'h01 << ST_ENABLE) & {8{enable_reg}}
                           | (8'h01 << ST_ACTIVE) & {8{cpu_halted}}
                           | (8'h01 << ST_CLKSEL) & {8{clksel_reg}};
    wire [15:0] rdata_v    = need_exec ? core_rdata : 16'h0000;
    wire [15:0] tx_load    = (desc_reg.tx_len == B16)
                           ? (desc_reg.with_status ? {status_v, rdata_v[7:0]} : rdata_v)
                           : {(desc_reg.with_status ? status_v : rdata_v[7:0]), 8'h00};
    wire [15:0] tx_shifted = {tx_sh_reg[14:0], 1'b0};
    wire [15:0] rx_addr    = (desc_reg.rx_len == B24) ? rx_sh_reg[23:8] : rx_sh_reg[15:0];
    wire [15:0] req_addr   = desc_reg.addr_cmd ? rx_addr : last_addr_reg;
    wire        tx_bit     = tx_sh_reg[15];
    wire        tx_mode    = (state_reg == S_TX) && !ignore_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Bit engine

    bit_timer u_bit_timer (
        .mclk      (mclk),
        .rst_n     (rst_n),
        .tick      (tick),
        .line_in   (line_in),
        .tx_mode   (tx_mode),
        .tx_bit    (tx_bit),
        .sample_p  (sample_p),
        .rx_bit    (rx_bit),
        .timeout_p (timeout_p),
        .sync_p    (sync_p),
        .line_o    (line_o),
        .line_oe   (line_oe)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Clock divider, strap capture, control bits

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            alt_cnt_reg  <= '0;
            alt_tick_reg <= 1'b0;
        end
        else
        begin
            alt_cnt_reg  <= (alt_cnt_reg == 2'(ALT_DIV - 1)) ? 2'h0 : alt_cnt_reg + 2'h1;
            alt_tick_reg <= (alt_cnt_reg == 2'(ALT_DIV - 1));
        end
    end

    // Strap is caught on the first edge after release, never under reset
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            strap_done_reg      <= 1'b0;
            start_in_background <= 1'b0;
        end
        else if (!strap_done_reg)
        begin
            strap_done_reg      <= 1'b1;
            start_in_background <= ~line_in;
        end
    end

    // Control lives only behind the link, nowhere in the processor map
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            enable_reg <= CTL_RESET;
            clksel_reg <= CTL_RESET;
        end
        else if (exec_done && code_reg == CMD_WRITE_CONTROL && !ignore_reg)
        begin
            enable_reg <= rx_sh_reg[ST_ENABLE];
            clksel_reg <= rx_sh_reg[ST_CLKSEL];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Command sequencer

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            state_reg     <= S_CMD;
            desc_reg      <= '0;
            code_reg      <= '0;
            nbits_reg     <= '0;
            rx_sh_reg     <= '0;
            tx_sh_reg     <= '0;
            last_addr_reg <= '0;
            ignore_reg    <= 1'b0;
            pend_reg      <= 1'b0;
            core_req      <= '0;
        end
        else
        begin
            core_req.valid <= 1'b0;
            if (abort)
            begin
                state_reg <= S_CMD;
                nbits_reg <= '0;
                pend_reg  <= 1'b0;
            end
            else
            begin
                case (state_reg)
                    S_CMD:
                        if (sample_p)
                        begin
                            code_reg  <= code_shift;
                            nbits_reg <= code_done ? 5'h00 : nbits_reg + 5'h01;
                            if (code_done && new_desc.known)
                            begin
                                desc_reg   <= new_desc;
                                ignore_reg <= new_ignore;
                                state_reg  <= (new_desc.rx_len != B0) ? S_RX : S_EXEC;
                            end
                        end
                    S_RX:
                        if (sample_p)
                        begin
                            rx_sh_reg <= {rx_sh_reg[22:0], rx_bit};
                            nbits_reg <= rx_done ? 5'h00 : nbits_reg + 5'h01;
                            if (rx_done)
                                state_reg <= S_EXEC;
                        end
                    S_EXEC:
                        // Work done inside the host's delay slot
                        if (exec_done)
                        begin
                            pend_reg  <= 1'b0;
                            tx_sh_reg <= tx_load;
                            state_reg <= (desc_reg.tx_len != B0) ? S_TX : S_CMD;
                        end
                        else if (need_exec && !pend_reg)
                        begin
                            pend_reg       <= 1'b1;
                            core_req.valid <= 1'b1;
                            core_req.code  <= code_reg;
                            core_req.addr  <= req_addr;
                            core_req.wdata <= rx_sh_reg[15:0];
                            if (desc_reg.addr_cmd)
                                last_addr_reg <= rx_addr;
                        end
                    S_TX:
                        if (sample_p)
                        begin
                            tx_sh_reg <= tx_shifted;
                            nbits_reg <= tx_done ? 5'h00 : nbits_reg + 5'h01;
                            if (tx_done)
                                state_reg <= S_CMD;
                        end
                    default: state_reg <= S_CMD;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);

    sequence req_issue;
        state_reg == S_EXEC && core_req.valid;
    endsequence

    a_abort_idle: assert property (timeout_p |=> state_reg == S_CMD && !core_req.valid)
        else $error("command survived link timeout");
    a_halted_gate: assert property (core_req.valid && desc_reg.halted_only |-> cpu_halted
        || $past(cpu_halted))
        else $error("halted-mode command issued while running");
    a_bg_enable: assert property (core_req.valid && core_req.code == CMD_BACKGROUND
        |-> enable_reg)
        else $error("background entry issued without enable");
    a_tx_msb_first: assert property (sample_p && state_reg == S_TX && !abort
        |=> tx_sh_reg == $past(tx_shifted))
        else $error("transmit word not shifted MSB first");
    a_exec_finish: assert property (req_issue ##1 core_ack |=> state_reg != S_EXEC)
        else $error("execution did not finish on acknowledge");
    a_clock_select: assert property (!clksel_reg |-> tick)
        else $error("bus clock selected but debug tick missing");
endmodule

// ==== test/host_pod.sv ====
// Host pod model: opens every bit and writes or reads the debug line
`timescale 1ns/100ps
module host_pod (
    input  wire logic mclk,
    input  wire logic line_o,
    input  wire logic line_oe,
    output logic      line_in
);
    logic drv_low = 1'b0;
    int   scale   = 1;
    // Wire-AND of both parties over the pull-up
    assign line_in = !(drv_low || (line_oe && !line_o));
    task automatic put(input logic [7:0] v, input int n);
        for (int i = n - 1; i >= 0; i--)
        begin
            drv_low = 1'b1;
            repeat ((v[i] ? 4 : 13) * scale) @(negedge mclk);
            drv_low = 1'b0;
            repeat ((v[i] ? 12 : 3) * scale) @(negedge mclk);
        end
    endtask
    task automatic get(output logic [7:0] v);
        for (int i = 7; i >= 0; i--)
        begin
            drv_low = 1'b1;
            // Released well before the speed-up pulse
            repeat (3 * scale) @(negedge mclk);
            drv_low = 1'b0;
            repeat (7 * scale) @(negedge mclk);
            v[i] = line_in;
            // Target ends a zero past the nominal bit; leave it room
            repeat (8 * scale) @(negedge mclk);
        end
    endtask
    task automatic hold_low(input int n);
        drv_low = 1'b1;
        repeat (n) @(negedge mclk);
        drv_low = 1'b0;
    endtask
endmodule

// ==== test/single_wire_debug_link_tb.sv ====
// Self-checking bench for the single-wire debug link
`timescale 1ns/100ps
module single_wire_debug_link_tb;
    import link_pkg::*;
    logic mclk, rst_n, line_in, line_o, line_oe, cpu_halted, start_in_background;
    logic core_ack = 1'b0;
    logic req_q = 1'b0;
    logic [15:0] core_rdata = 16'h0000;
    core_req_t core_req;
    int n_mismatch = 0;
    int n_tests = 0;
    int n_req = 0;
    logic [7:0] v;
    single_wire_debug_link single_wire_debug_link_i (.mclk(mclk), .rst_n(rst_n),
        .line_in(line_in), .line_o(line_o), .line_oe(line_oe), .cpu_halted(cpu_halted),
        .core_ack(core_ack), .core_rdata(core_rdata), .core_req(core_req),
        .start_in_background(start_in_background));
    host_pod host_pod_i (.mclk(mclk), .line_o(line_o), .line_oe(line_oe), .line_in(line_in));
    ////////////////////////////////////////////////////////////////
    initial
    begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    // Core answers one cycle after each request
    always @(posedge mclk)
        if (core_req.valid === 1'b1)
            n_req <= n_req + 1;
    always @(negedge mclk)
    begin
        req_q <= (core_req.valid === 1'b1);
        core_ack <= req_q;
        core_rdata <= ~core_req.addr;
    end
    task automatic check(input string what, input logic [15:0] e, input logic [15:0] g);
        n_tests++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic status(input logic [7:0] e);
        host_pod_i.put(CMD_READ_STATUS, 8);
        host_pod_i.get(v);
        check("status", {8'h00, e}, {8'h00, v});
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic t_refuse;
        host_pod_i.put(CMD_READ_A, 8);
        repeat (20) @(negedge mclk);
        host_pod_i.get(v);
        check("refused read", 16'h00ff, {8'h00, v});
        host_pod_i.put(CMD_BACKGROUND, 8);
        repeat (20) @(negedge mclk);
        check("refused requests", 16'h0000, n_req[15:0]);
        status(8'h00);
        $display("refuse done");
    endtask
    task automatic t_read;
        host_pod_i.put(CMD_READ_BYTE, 8);
        host_pod_i.put(8'h12, 8);
        host_pod_i.put(8'h34, 8);
        repeat (20) @(negedge mclk);
        host_pod_i.get(v);
        check("read data", 16'h00cb, {8'h00, v});
        check("read addr", 16'h1234, core_req.addr);
        check("read code", {8'h00, CMD_READ_BYTE}, {8'h00, core_req.code});
        host_pod_i.put(CMD_READ_PC, 8);
        repeat (20) @(negedge mclk);
        host_pod_i.get(v);
        check("pc high", 16'h00ed, {8'h00, v});
        host_pod_i.get(v);
        check("pc low", 16'h00cb, {8'h00, v});
        $display("read done");
    endtask
    task automatic t_write;
        host_pod_i.put(CMD_WRITE_BYTE, 8);
        host_pod_i.put(8'h56, 8);
        host_pod_i.put(8'h78, 8);
        host_pod_i.put(8'h9a, 8);
        repeat (20) @(negedge mclk);
        check("write addr", 16'h5678, core_req.addr);
        check("write data", 16'h009a, {8'h00, core_req.wdata[7:0]});
        $display("write done");
    endtask
    task automatic t_ctrl;
        host_pod_i.put(CMD_WRITE_CONTROL, 8);
        host_pod_i.put(8'h80, 8);
        repeat (20) @(negedge mclk);
        status(8'hc0);
        host_pod_i.put(CMD_BACKGROUND, 8);
        repeat (20) @(negedge mclk);
        check("background code", {8'h00, CMD_BACKGROUND}, {8'h00, core_req.code});
        $display("control done");
    endtask
    task automatic t_timeout;
        host_pod_i.put(CMD_WRITE_BYTE, 8);
        host_pod_i.put(8'h12, 4);
        repeat (600) @(negedge mclk);
        check("aborted write", 16'h0004, n_req[15:0]);
        status(8'hc0);
        $display("timeout done");
    endtask
    task automatic t_sync;
        int n_low = 0;
        host_pod_i.put(CMD_WRITE_BYTE, 8);
        host_pod_i.hold_low(140);
        repeat (300) @(negedge mclk)
            if (line_in === 1'b0)
                n_low++;
        check("sync low time", 16'(SYNC_PULSE), n_low[15:0]);
        check("sync abort", 16'h0004, n_req[15:0]);
        status(8'hc0);
        $display("sync done");
    endtask
    task automatic t_alt;
        host_pod_i.put(CMD_WRITE_CONTROL, 8);
        host_pod_i.put(8'h84, 8);
        repeat (20) @(negedge mclk);
        host_pod_i.scale = ALT_DIV;
        status(8'hc4);
        $display("alternate clock done");
    endtask
    task automatic end_of_test;
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(negedge mclk);
        n_mismatch++;
        end_of_test;
    end
    initial
    begin
        rst_n = 1'b0;
        cpu_halted = 1'b0;
        repeat (12) @(negedge mclk);
        rst_n = 1'b1;
        repeat (3) @(negedge mclk);
        check("strap high", 16'h0000, {15'h0, start_in_background});
        t_refuse;
        cpu_halted = 1'b1;
        t_read;
        t_write;
        t_ctrl;
        t_timeout;
        t_sync;
        t_alt;
        // Line held low across reset selects background start
        host_pod_i.drv_low = 1'b1;
        rst_n = 1'b0;
        repeat (3) @(negedge mclk);
        rst_n = 1'b1;
        repeat (2) @(negedge mclk);
        host_pod_i.drv_low = 1'b0;
        check("strap low", 16'h0001, {15'h0, start_in_background});
        end_of_test;
    end
endmodule
